//--- bench/tb.sv
// Self-checking bench for the port ingress control block
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.svh"
module tb;
	logic        aclk, aresetn;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [2:0]  ing_valid, ing_bcast, ing_ipv4, ing_tagged, egr_valid, egr_rx_tagged;
	logic [5:0]  ing_dscp_queue, egr_src_port, cls_queue;
	logic [8:0]  ing_tag_prio;
	logic [2:0]  cls_valid, cls_storm, ins_valid, ins_tag;
	logic [35:0] ins_vid, exp_vid;
	logic [7:0]  cfg [3];
	logic [11:0] vid_m [3];
	logic [15:0] map_m;
	logic [5:0]  gate_m, exp_cq;
	logic [2:0]  exp_tag;
	logic [31:0] seed;
	int          fail_count, n_compared;

	ppc_port_ctrl ppc_port_ctrl_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ing_valid(ing_valid), .ing_bcast(ing_bcast), .ing_ipv4(ing_ipv4),
		.ing_dscp_queue(ing_dscp_queue), .ing_tagged(ing_tagged), .ing_tag_prio(ing_tag_prio),
		.cls_valid(cls_valid), .cls_queue(cls_queue), .cls_storm(cls_storm),
		.egr_valid(egr_valid), .egr_rx_tagged(egr_rx_tagged), .egr_src_port(egr_src_port),
		.ins_valid(ins_valid), .ins_tag(ins_tag), .ins_vid(ins_vid));

	// Free-running 10 MHz clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Galois shift register, so every run draws the same values
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h8020_0003 : 32'h0000_0000);
	endfunction : lfsr

	function automatic logic [7:0] port_off(input int p);
		return (p == 0) ? `PPC_OFF_PORT1 : (p == 1) ? `PPC_OFF_PORT2 : `PPC_OFF_PORT3;
	endfunction : port_off

	// Queue choice: hits OR together, fallback field only when nothing hits
	function automatic logic [1:0] exp_q(input logic [7:0] c, input logic tg,
			input logic [2:0] pr, input logic v4, input logic [1:0] dq);
		logic ph;
		logic dh;
		ph = c[5] & tg;
		dh = c[6] & v4;
		if (!(ph | dh))
			return c[4:3];
		return (ph ? map_m[2*pr +: 2] : 2'b00) | (dh ? dq : 2'b00);
	endfunction : exp_q

	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task automatic bad(input string msg);
		fail_count++;
		$display("Error at %0t: %s", $time, msg);
	endtask : bad

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
			bad($sformatf("read data %h, expected %h", got, exp));
	endtask : chk_data

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		n_compared++;
		if (got !== exp)
			bad($sformatf("response %h, expected %h", got, exp));
	endtask : chk_resp

	task automatic chk_out(input logic [35:0] got, input logic [35:0] exp, input string what);
		n_compared++;
		if (got !== exp)
			bad($sformatf("%s is %h, expected %h", what, got, exp));
	endtask : chk_out

	// Write: both halves offered together, each released once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				chk_resp(bresp, er);
				return;
			end
		end
		bad("write response never came");
		wrap_up();
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				chk_data(rdata, ed);
				chk_resp(rresp, er);
				return;
			end
		end
		bad("read data never came");
		wrap_up();
	endtask : axi_read

	// One random arrival on any subset of ports; idle ports keep their queue
	task automatic send_ing();
		logic [2:0] es;
		seed = lfsr(seed);
		@(posedge aclk);
		{ing_valid, ing_bcast, ing_ipv4, ing_tagged, ing_dscp_queue, ing_tag_prio} <= seed[26:0];
		@(posedge aclk);
		ing_valid <= 3'b000;
		es = seed[26:24] & seed[23:21] & {cfg[2][7], cfg[1][7], cfg[0][7]};
		for (int p = 0; p < 3; p++)
			if (seed[24+p])
				exp_cq[2*p +: 2] = exp_q(cfg[p], seed[15+p], seed[3*p +: 3], seed[18+p],
					seed[9+2*p +: 2]);
		#1;
		chk_out(36'(cls_valid), 36'(seed[26:24]), "cls_valid");
		chk_out(36'(cls_queue), 36'(exp_cq), "cls_queue");
		chk_out(36'(cls_storm), 36'(es), "cls_storm");
	endtask : send_ing

	task automatic send_egr();
		logic [1:0] s;
		seed = lfsr(seed);
		@(posedge aclk);
		{egr_valid, egr_rx_tagged, egr_src_port} <= seed[11:0];
		@(posedge aclk);
		egr_valid <= 3'b000;
		for (int o = 0; o < 3; o++)
			if (seed[9+o]) begin
				s = seed[2*o +: 2];
				exp_tag[o] = cfg[o][2] & (gate_m == 6'h3F) & (s != 2'd3) & !seed[6+o];
				exp_vid[12*o +: 12] = (s == 2'd3) ? 12'h000 : vid_m[s];
			end
		#1;
		chk_out(36'(ins_valid), 36'(seed[11:9]), "ins_valid");
		chk_out(36'(ins_tag), 36'(exp_tag), "ins_tag");
		chk_out(ins_vid, exp_vid, "ins_vid");
	endtask : send_egr

	// Main sequence
	initial begin
		{aresetn, awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
		{ing_valid, ing_bcast, ing_ipv4, ing_tagged, ing_dscp_queue, ing_tag_prio} = '0;
		{egr_valid, egr_rx_tagged, egr_src_port} = '0;
		{exp_cq, exp_tag, exp_vid, fail_count, n_compared} = '0;
		seed = 32'd85050;
		map_m = 16'hFA50;
		gate_m = 6'h00;
		for (int p = 0; p < 3; p++) begin
			cfg[p] = 8'h00;
			vid_m[p] = 12'h001;
		end
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values, unmapped place refused both ways
		for (int p = 0; p < 3; p++)
			axi_read(port_off(p), 32'h0000_0000, `PPC_RESP_OKAY);
		axi_read(`PPC_OFF_PRIO_MAP, 32'h0000_FA50, `PPC_RESP_OKAY);
		axi_read(8'h14, 32'h0000_0000, `PPC_RESP_SLVERR);
		axi_write(8'h14, 32'h0000_00FF, 4'hF, `PPC_RESP_SLVERR);
		$display("test reset_values done");
		// Each port byte separate; cleared low strobe must leave it alone
		for (int k = 0; k < 4; k++)
			for (int p = 0; p < 3; p++) begin
				seed = lfsr(seed);
				axi_write(port_off(p), seed, 4'hF, `PPC_RESP_OKAY);
				cfg[p] = seed[7:0];
				axi_write(port_off(p), ~seed, 4'hE, `PPC_RESP_OKAY);
				axi_read(port_off(p), {24'h0, cfg[p]}, `PPC_RESP_OKAY);
			end
		$display("test port_bytes done");
		// Fallback field alone, all four values including queue 3
		for (int d = 0; d < 4; d++) begin
			for (int p = 0; p < 3; p++) begin
				cfg[p] = 8'(d << 3);
				axi_write(port_off(p), 32'(cfg[p]), 4'hF, `PPC_RESP_OKAY);
			end
			repeat (3) send_ing();
		end
		$display("test fallback done");
		// Random settings rewritten on the fly between bursts of four arrivals
		for (int k = 0; k < 12; k++) begin
			seed = lfsr(seed);
			map_m = seed[15:0];
			axi_write(`PPC_OFF_PRIO_MAP, seed, 4'hF, `PPC_RESP_OKAY);
			for (int p = 0; p < 3; p++) begin
				seed = lfsr(seed);
				cfg[p] = seed[7:0];
				axi_write(port_off(p), seed, 4'hF, `PPC_RESP_OKAY);
			end
			repeat (4) send_ing();
		end
		axi_read(`PPC_OFF_STATUS, 32'(exp_cq), `PPC_RESP_OKAY);
		$display("test classify done");
		// Insertion: held off until the gate bits are all set
		for (int p = 0; p < 3; p++) begin
			seed = lfsr(seed);
			vid_m[p] = seed[11:0];
			axi_write(8'(`PPC_OFF_VID1 + 4*p), seed, 4'hF, `PPC_RESP_OKAY);
			axi_read(8'(`PPC_OFF_VID1 + 4*p), 32'(vid_m[p]), `PPC_RESP_OKAY);
			cfg[p] = cfg[p] | 8'h04;
			axi_write(port_off(p), 32'(cfg[p]), 4'hF, `PPC_RESP_OKAY);
		end
		repeat (6) send_egr();
		gate_m = 6'h3F;
		axi_write(`PPC_OFF_INS_GATE, 32'h0000_003F, 4'hF, `PPC_RESP_OKAY);
		axi_read(`PPC_OFF_INS_GATE, 32'h0000_003F, `PPC_RESP_OKAY);
		repeat (24) send_egr();
		cfg[1] = cfg[1] & 8'hFB;
		axi_write(`PPC_OFF_PORT2, 32'(cfg[1]), 4'hF, `PPC_RESP_OKAY);
		repeat (12) send_egr();
		$display("test insertion done");
		wrap_up();
	end
endmodule : tb
`default_nettype wire

//--- logic/ppc_classify.sv
// Ingress priority classifier and storm flag for one port
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.svh"
module ppc_classify (
	input  wire logic             aclk,       // Switch clock
	input  wire logic             aresetn,    // Synchronous reset, active low
	input  wire ppc_pkg::ppc_cfg_t cfg,       // Live port control byte
	input  wire ppc_pkg::ppc_map_t prio_map,  // Tag priority to queue map
	input  wire logic             in_valid,   // Packet descriptor present
	input  wire logic             in_bcast,   // Broadcast packet
	input  wire logic             in_ipv4,    // IPv4 packet with code point
	input  wire ppc_pkg::ppc_queue_t in_dscp_queue, // Queue from code point table
	input  wire logic             in_tagged,  // Arrived with 802.1p/q tag
	input  wire logic [2:0]       in_tag_prio, // Tag user priority
	output logic                  out_valid,  // Result valid pulse
	output ppc_pkg::ppc_queue_t   out_queue,  // Chosen queue, held
	output logic                  out_storm   // Apply storm protection, pulse
);
	import ppc_pkg::*;

	logic       prio_hit;
	logic       dscp_hit;
	ppc_queue_t map_queue;
	ppc_queue_t next_queue;

	// Settings are read live, so a write applies to the next packet
	always_comb begin
		prio_hit   = cfg[`PPC_BIT_PRIO_EN] & in_tagged;
		dscp_hit   = cfg[`PPC_BIT_DSCP_EN] & in_ipv4;
		map_queue  = prio_map[{in_tag_prio, 1'b0} +: 2];
		next_queue = cfg[`PPC_FLD_DEF_LO +: 2];
		if (prio_hit || dscp_hit) begin
			next_queue = (prio_hit ? map_queue : 2'h0) | (dscp_hit ? in_dscp_queue : 2'h0);
		end
	end

	// Registered result; queue holds until the next packet
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_valid <= 1'b0;
			out_storm <= 1'b0;
			out_queue <= 2'h0;
		end else begin
			out_valid <= in_valid;
			out_storm <= in_valid & in_bcast & cfg[`PPC_BIT_STORM];
			if (in_valid) begin
				out_queue <= next_queue;
			end
		end
	end

	a_storm_follows_en: assert property (@(posedge aclk) disable iff (!aresetn)
		in_valid && in_bcast |=> out_storm == $past(cfg[`PPC_BIT_STORM]))
		else $error("storm flag does not follow enable bit");
	a_default_queue: assert property (@(posedge aclk) disable iff (!aresetn)
		in_valid && !cfg[`PPC_BIT_PRIO_EN] && !cfg[`PPC_BIT_DSCP_EN]
		|=> out_valid && out_queue == $past(cfg[`PPC_FLD_DEF_LO +: 2]))
		else $error("unclassified packet not in port default queue");
	a_tag_map_or: assert property (@(posedge aclk) disable iff (!aresetn)
		in_valid && cfg[`PPC_BIT_PRIO_EN] && in_tagged && cfg[`PPC_BIT_DSCP_EN] && in_ipv4
		|=> out_queue == ($past(map_queue) | $past(in_dscp_queue)))
		else $error("combined classification is not the OR of both results");
endmodule : ppc_classify
`default_nettype wire

//--- logic/ppc_defines.svh
// Offsets, field positions, reset values and widths of the port ingress control block
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH

// Bus address width and register byte offsets
`define PPC_ADDR_W          8
`define PPC_OFF_PRIO_MAP    8'h04
`define PPC_OFF_INS_GATE    8'h08
`define PPC_OFF_PORT1       8'h10
`define PPC_OFF_PORT2       8'h20
`define PPC_OFF_PORT3       8'h30
`define PPC_OFF_VID1        8'h44
`define PPC_OFF_VID2        8'h48
`define PPC_OFF_VID3        8'h4C
`define PPC_OFF_STATUS      8'h50

// Port control field positions
`define PPC_BIT_STORM       7
`define PPC_BIT_DSCP_EN     6
`define PPC_BIT_PRIO_EN     5
`define PPC_FLD_DEF_LO      3
`define PPC_BIT_TAG_INS     2

// Reset values
`define PPC_RST_PORT        8'h00
`define PPC_RST_PRIO_MAP    16'hFA50
`define PPC_RST_INS_GATE    6'h00
`define PPC_INS_GATE_ALL    6'h3F
`define PPC_RST_VID         12'h001

// Bus responses
`define PPC_RESP_OKAY       2'h0
`define PPC_RESP_SLVERR     2'h2

`endif

//--- logic/ppc_pkg.sv
// Shared types of the port ingress control block
`default_nettype none
package ppc_pkg;
	typedef logic [1:0]  ppc_queue_t;   // Priority queue number
	typedef logic [11:0] ppc_vid_t;     // VLAN identifier
	typedef logic [7:0]  ppc_cfg_t;     // One port control byte
	typedef logic [15:0] ppc_map_t;     // Eight 2-bit tag priority to queue fields
endpackage : ppc_pkg
`default_nettype wire

//--- logic/ppc_port_ctrl.sv
// Per-port ingress control registers with AXI4-Lite access and per-port logic
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.svh"
// What this block does
// - Three identical port control bytes at byte offsets 0x10, 0x20, 0x30.
// - Bit 7 set turns on broadcast storm protection for that port's arrivals.
// - Bit 6 set classifies arriving IPv4 packets by their code point.
// - Bit 5 set classifies arriving tagged packets by their user priority.
// - Bits 4-3 give the fallback queue 0, 1, 2 or 3 when unclassified.
// - Fallback value 11 selects queue 3, the highest of four.
// - Bit 2 set adds a tag to untagged packets leaving that port, once all six insertion gate bits are set.
// - Packets already tagged on arrival never get a second tag.
// - Inserted tag carries the arrival port's default VID.
// - Eight tag priorities map to queues through programmable 2-bit fields.
module ppc_port_ctrl (
	input  wire logic                   aclk,           // Switch clock, 10 MHz
	input  wire logic                   aresetn,        // Synchronous reset, active low
	input  wire logic [`PPC_ADDR_W-1:0] s_axi_awaddr,   // Write address
	input  wire logic                   s_axi_awvalid,  // Write address valid
	output logic                        s_axi_awready,  // Write address ready
	input  wire logic [31:0]            s_axi_wdata,    // Write data
	input  wire logic [3:0]             s_axi_wstrb,    // Write byte strobes
	input  wire logic                   s_axi_wvalid,   // Write data valid
	output logic                        s_axi_wready,   // Write data ready
	output logic [1:0]                  s_axi_bresp,    // Write response
	output logic                        s_axi_bvalid,   // Write response valid
	input  wire logic                   s_axi_bready,   // Write response ready
	input  wire logic [`PPC_ADDR_W-1:0] s_axi_araddr,   // Read address
	input  wire logic                   s_axi_arvalid,  // Read address valid
	output logic                        s_axi_arready,  // Read address ready
	output logic [31:0]                 s_axi_rdata,    // Read data
	output logic [1:0]                  s_axi_rresp,    // Read response
	output logic                        s_axi_rvalid,   // Read data valid
	input  wire logic                   s_axi_rready,   // Read data ready
	input  wire logic [2:0]             ing_valid,      // Arrival descriptor, per port
	input  wire logic [2:0]             ing_bcast,      // Broadcast arrival, per port
	input  wire logic [2:0]             ing_ipv4,       // IPv4 arrival, per port
	input  wire logic [5:0]             ing_dscp_queue, // Code point queue, 2 bits a port
	input  wire logic [2:0]             ing_tagged,     // Tagged arrival, per port
	input  wire logic [8:0]             ing_tag_prio,   // User priority, 3 bits a port
	output logic [2:0]                  cls_valid,      // Classification valid, per port
	output logic [5:0]                  cls_queue,      // Queue, 2 bits a port
	output logic [2:0]                  cls_storm,      // Storm protection applies
	input  wire logic [2:0]             egr_valid,      // Departure descriptor, per port
	input  wire logic [2:0]             egr_rx_tagged,  // Departing packet was tagged
	input  wire logic [5:0]             egr_src_port,   // Arrival port, 2 bits a port
	output logic [2:0]                  ins_valid,      // Insertion decision valid
	output logic [2:0]                  ins_tag,        // Insert a tag, per port
	output logic [35:0]                 ins_vid         // Tag VID, 12 bits a port
);
	import ppc_pkg::*;

	// Register storage
	ppc_cfg_t  port_ctrl [3];
	ppc_map_t  prio_map;
	logic [5:0] ins_gate;
	ppc_vid_t  port_vid [3];

	// Write channel holding state
	logic [`PPC_ADDR_W-1:0] aw_addr;
	logic                   aw_have;
	logic [31:0]            w_data;
	logic [3:0]             w_strb;
	logic                   w_have;
	logic                   do_write;
	logic                   wr_hit;
	logic                   rd_hit;
	logic [31:0]            rd_word;
	logic                   gate_ok;

	assign do_write = aw_have & w_have & !s_axi_bvalid;
	assign gate_ok  = (ins_gate == `PPC_INS_GATE_ALL);

	// Address channel capture; address and data may come in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have       <= 1'b0;
			aw_addr       <= '0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have       <= 1'b1;
			aw_addr       <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (do_write) begin
			aw_have <= 1'b0;
		end else if (!aw_have && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	// Data channel capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have       <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have       <= 1'b1;
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (do_write) begin
			w_have <= 1'b0;
		end else if (!w_have && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	// Write decode; unmapped addresses answer with a slave error
	always_comb begin
		unique case (aw_addr)
			`PPC_OFF_PORT1, `PPC_OFF_PORT2, `PPC_OFF_PORT3,
			`PPC_OFF_PRIO_MAP, `PPC_OFF_INS_GATE,
			`PPC_OFF_VID1, `PPC_OFF_VID2, `PPC_OFF_VID3, `PPC_OFF_STATUS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Write response, one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `PPC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `PPC_RESP_OKAY : `PPC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Port control bytes; the per-port logic reads them live
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 3; i++) begin
				port_ctrl[i] <= `PPC_RST_PORT;
			end
		end else if (do_write && w_strb[0]) begin
			unique case (aw_addr)
				`PPC_OFF_PORT1: port_ctrl[0] <= w_data[7:0];
				`PPC_OFF_PORT2: port_ctrl[1] <= w_data[7:0];
				`PPC_OFF_PORT3: port_ctrl[2] <= w_data[7:0];
				default: ;
			endcase
		end
	end

	// Global priority map and insertion gate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prio_map <= `PPC_RST_PRIO_MAP;
			ins_gate <= `PPC_RST_INS_GATE;
		end else if (do_write && aw_addr == `PPC_OFF_PRIO_MAP) begin
			if (w_strb[0]) prio_map[7:0]  <= w_data[7:0];
			if (w_strb[1]) prio_map[15:8] <= w_data[15:8];
		end else if (do_write && aw_addr == `PPC_OFF_INS_GATE && w_strb[0]) begin
			ins_gate <= w_data[5:0];
		end
	end

	// Default VIDs of the three ports
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 3; i++) begin
				port_vid[i] <= `PPC_RST_VID;
			end
		end else if (do_write) begin
			for (int i = 0; i < 3; i++) begin
				if (aw_addr == `PPC_OFF_VID1 + 8'(4 * i)) begin
					if (w_strb[0]) port_vid[i][7:0]  <= w_data[7:0];
					if (w_strb[1]) port_vid[i][11:8] <= w_data[11:8];
				end
			end
		end
	end

	// Read decode; status shows the last queue chosen on each port
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		unique case (s_axi_araddr)
			`PPC_OFF_PORT1:    rd_word = 32'(port_ctrl[0]);
			`PPC_OFF_PORT2:    rd_word = 32'(port_ctrl[1]);
			`PPC_OFF_PORT3:    rd_word = 32'(port_ctrl[2]);
			`PPC_OFF_PRIO_MAP: rd_word = 32'(prio_map);
			`PPC_OFF_INS_GATE: rd_word = 32'(ins_gate);
			`PPC_OFF_VID1:     rd_word = 32'(port_vid[0]);
			`PPC_OFF_VID2:     rd_word = 32'(port_vid[1]);
			`PPC_OFF_VID3:     rd_word = 32'(port_vid[2]);
			`PPC_OFF_STATUS:   rd_word = 32'(cls_queue);
			default:           rd_hit  = 1'b0;
		endcase
	end

	// Read channel; one read in flight, address taken only while idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `PPC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? `PPC_RESP_OKAY : `PPC_RESP_SLVERR;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// One classifier and one tag decision per port
	for (genvar p = 0; p < 3; p++) begin : g_port
		ppc_classify u_cls (
			.aclk          (aclk),
			.aresetn       (aresetn),
			.cfg           (port_ctrl[p]),
			.prio_map      (prio_map),
			.in_valid      (ing_valid[p]),
			.in_bcast      (ing_bcast[p]),
			.in_ipv4       (ing_ipv4[p]),
			.in_dscp_queue (ing_dscp_queue[2*p +: 2]),
			.in_tagged     (ing_tagged[p]),
			.in_tag_prio   (ing_tag_prio[3*p +: 3]),
			.out_valid     (cls_valid[p]),
			.out_queue     (cls_queue[2*p +: 2]),
			.out_storm     (cls_storm[p])
		);
		ppc_tag_insert u_ins (
			.aclk          (aclk),
			.aresetn       (aresetn),
			.ins_en        (port_ctrl[p][`PPC_BIT_TAG_INS]),
			.gate_ok       (gate_ok),
			.vid1          (port_vid[0]),
			.vid2          (port_vid[1]),
			.vid3          (port_vid[2]),
			.in_valid      (egr_valid[p]),
			.in_rx_tagged  (egr_rx_tagged[p]),
			.in_src_port   (egr_src_port[2*p +: 2]),
			.out_valid     (ins_valid[p]),
			.out_insert    (ins_tag[p]),
			.out_vid       (ins_vid[12*p +: 12])
		);
	end

	a_port2_write: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && aw_addr == `PPC_OFF_PORT2 && w_strb[0]
		|=> port_ctrl[1] == $past(w_data[7:0]) && s_axi_bvalid)
		else $error("write to second port byte not stored");
	a_unmapped_err: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && !rd_hit
		|=> s_axi_rvalid && s_axi_rresp == `PPC_RESP_SLVERR)
		else $error("unmapped read did not answer with error");
	a_map_top_prio: assert property (@(posedge aclk) disable iff (!aresetn)
		ing_valid[0] && ing_tagged[0] && ing_tag_prio[2:0] == 3'h7
		&& port_ctrl[0][`PPC_BIT_PRIO_EN] && !port_ctrl[0][`PPC_BIT_DSCP_EN]
		|=> cls_queue[1:0] == $past(prio_map[15:14]))
		else $error("top tag priority not mapped through its field");
	a_live_setting: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && aw_addr == `PPC_OFF_PORT3 && w_strb[0] && !w_data[`PPC_BIT_PRIO_EN]
		&& !w_data[`PPC_BIT_DSCP_EN] ##[1:4] ing_valid[2]
		|=> cls_queue[5:4] == $past(w_data[`PPC_FLD_DEF_LO +: 2]))
		else $error("new default queue not used by next packet");
	a_gate_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
		egr_valid[2] && !gate_ok |=> !ins_tag[2])
		else $error("tag inserted while global gate bits incomplete");

	// Bus refusal and storage checks; only one write and one read are ever held
	a_ready_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channel ready while response pending");
	a_read_refused: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read address ready while read data pending");
	a_write_slverr: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && !wr_hit
		|=> s_axi_bvalid && s_axi_bresp == `PPC_RESP_SLVERR)
		else $error("unmapped write did not answer with error");
	a_low_strobe: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && aw_addr == `PPC_OFF_PORT1 && !w_strb[0] |=> $stable(port_ctrl[0]))
		else $error("port byte changed with its strobe clear");
	a_port3_read: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `PPC_OFF_PORT3
		|=> s_axi_rdata == {24'h00_0000, $past(port_ctrl[2])})
		else $error("third port byte read back wrong");
	a_status_read: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `PPC_OFF_STATUS
		|=> s_axi_rdata == {26'h000_0000, $past(cls_queue)})
		else $error("status does not show the chosen queues");
	a_vid3_write: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && aw_addr == `PPC_OFF_VID3 && w_strb[0] && w_strb[1]
		|=> port_vid[2] == $past(w_data[11:0]))
		else $error("third port default VID not stored");
	a_gate_opens: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write && aw_addr == `PPC_OFF_INS_GATE && w_strb[0]
		|=> gate_ok == ($past(w_data[5:0]) == `PPC_INS_GATE_ALL))
		else $error("insertion gate does not follow its six bits");
endmodule : ppc_port_ctrl
`default_nettype wire

//--- logic/ppc_tag_insert.sv
// Egress tag insertion decision for one output port
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.svh"
module ppc_tag_insert (
	input  wire logic             aclk,          // Switch clock
	input  wire logic             aresetn,       // Synchronous reset, active low
	input  wire logic             ins_en,        // Tag insertion bit of this port
	input  wire logic             gate_ok,       // Global insertion bits all set
	input  wire ppc_pkg::ppc_vid_t vid1,         // Default VID of port 1
	input  wire ppc_pkg::ppc_vid_t vid2,         // Default VID of port 2
	input  wire ppc_pkg::ppc_vid_t vid3,         // Default VID of port 3
	input  wire logic             in_valid,      // Packet leaving this port
	input  wire logic             in_rx_tagged,  // Packet had a tag on reception
	input  wire logic [1:0]       in_src_port,   // Ingress port, 0..2
	output logic                  out_valid,     // Decision valid pulse
	output logic                  out_insert,    // Add a tag, held
	output ppc_pkg::ppc_vid_t     out_vid        // VID for that tag, held
);
	import ppc_pkg::*;

	ppc_vid_t src_vid;
	logic     src_ok;

	// VID of the arrival port, never of this output port
	always_comb begin
		src_ok = 1'b1;
		unique case (in_src_port)
			2'h0: src_vid = vid1;
			2'h1: src_vid = vid2;
			2'h2: src_vid = vid3;
			default: begin
				src_vid = 12'h000;
				src_ok  = 1'b0;
			end
		endcase
	end

	// Already tagged packets pass untouched; no double tag here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_valid  <= 1'b0;
			out_insert <= 1'b0;
			out_vid    <= 12'h000;
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				out_insert <= ins_en & gate_ok & src_ok & !in_rx_tagged;
				out_vid    <= src_vid;
			end
		end
	end

	a_insert_untagged: assert property (@(posedge aclk) disable iff (!aresetn)
		in_valid && ins_en && gate_ok && !in_rx_tagged && in_src_port != 2'h3
		|=> out_valid && out_insert)
		else $error("untagged packet did not get a tag");
	a_no_second_tag: assert property (@(posedge aclk) disable iff (!aresetn)
		in_valid && in_rx_tagged |=> !out_insert)
		else $error("tagged packet received a second tag");
	a_vid_of_source: assert property (@(posedge aclk) disable iff (!aresetn)
		in_valid && in_src_port == 2'h1 |=> out_vid == $past(vid2))
		else $error("inserted VID is not the ingress port VID");
endmodule : ppc_tag_insert
`default_nettype wire
